// *** hdl/cis_map.vh ***
// Encodings, field positions, reset values and widths of the core subset.
//----------------------------------------------------------------------
// Operation
// - Add-literal adds immediate to work, sets flags
// - Add-literal opcode 11111x, low eight bits immediate
// - Four quarter phases: decode, read, process, write
// - Add-register opcode 0111 adds work plus file
// - Destination bit picks work or file register
// - Branch loads eleven-bit immediate into PC low
// - Branch PC high from latch bits 4:3
// - Branch takes two cycles, second is idle
// - Increment opcode 1010, destination bit, zero only
// - Bias select cleared means external ladder bias
//----------------------------------------------------------------------
`ifndef CIS_MAP_VH
`define CIS_MAP_VH

`define CIS_OP_ALW_HI   13
`define CIS_OP_ALW_LO   9
`define CIS_OP_ALW_VAL  5'h1F
`define CIS_OP_FLD_HI   13
`define CIS_OP_FLD_LO   8
`define CIS_OP_AWF_VAL  6'h07
`define CIS_OP_INC_VAL  6'h0A
`define CIS_OP_BR_HI    13
`define CIS_OP_BR_LO    11
`define CIS_OP_BR_VAL   3'h5
`define CIS_DEST_BIT    7
`define CIS_FADDR_HI    6
`define CIS_LIT_HI      7
`define CIS_BR_LIT_HI   10
`define CIS_PCLH_HI     4
`define CIS_PCLH_LO     3
`define CIS_LCD_BIAS_BIT 4
`define CIS_W_RST       8'h00
`define CIS_PC_RST      13'h0000
`define CIS_LCD_RST     8'h00
`define CIS_FILE_RST    8'h00

`endif

// *** hdl/cis_alu.v ***
// Eight-bit adder producing sum, carry, digit carry and zero.
`timescale 1ns/1ps
module cis_alu (
   input  wire [7:0] a,
   input  wire [7:0] b,
   output wire [7:0] sum,
   output wire       carry,
   output wire       digit_carry_flag,
   output wire       zero
);
   wire [8:0] full;
   wire [4:0] low;

   // Sum wraps modulo 256; the ninth bit is the carry out.
   assign full             = {1'b0, a} + {1'b0, b};
   assign low              = {1'b0, a[3:0]} + {1'b0, b[3:0]};
   assign sum              = full[7:0];
   assign carry            = full[8];
   assign digit_carry_flag = low[4];
   assign zero             = (full[7:0] == 8'h00);
endmodule // cis_alu

// *** hdl/cis_core.v ***
// Decoder and executor for a four-instruction subset of an 8-bit core.
`timescale 1ns/1ps
`include "cis_map.vh"
module cis_core #(
   parameter FILE_DEPTH = 128
) (
   input  wire        CLK,
   input  wire        RST_N,
   input  wire [13:0] INSTR,
   input  wire [7:0]  PC_LATCH_HIGH,
   input  wire        LCD_BIAS_SOURCE_SELECT,
   output wire [12:0] PC,
   output wire [1:0]  PHASE,
   output wire        INSTR_FETCH,
   output wire [7:0]  WORK,
   output wire        CARRY,
   output wire        DIGIT_CARRY_FLAG,
   output wire        ZERO,
   output wire        BRANCH_BUSY,
   output wire        BIAS_PUMP_EN,
   output wire        BIAS_LADDER_EN,
   output wire [6:0]  FILE_ADDR,
   output wire [7:0]  FILE_DATA
);
   //-------------------------------------------------------------------
   // Quarter phase codes
   //-------------------------------------------------------------------
   // Binary codes; the phase counter simply steps through them in order.
   localparam [1:0] PH_DECODE  = 2'h0;
   localparam [1:0] PH_READ    = 2'h1;
   localparam [1:0] PH_PROCESS = 2'h2;
   localparam [1:0] PH_WRITE   = 2'h3;

   //-------------------------------------------------------------------
   // Quarter phases and instruction register
   //-------------------------------------------------------------------
   reg  [1:0]  phase_q;
   reg  [13:0] ir_q;
   reg  [7:0]  opnd_q;
   reg  [7:0]  res_q;
   reg         c_res_q;
   reg         dgc_res_q;
   reg         z_res_q;
   reg         nop_q;
   reg  [12:0] pc_q;
   reg  [7:0]  w_q;
   reg         c_q;
   reg         dgc_q;
   reg         z_q;
   wire [7:0]  file_rd [0:FILE_DEPTH-1];
   wire        file_we;
   genvar      gi;

   wire        is_alw;
   wire        is_awf;
   wire        is_inc;
   wire        is_br;
   wire        dest;
   wire [6:0]  faddr;
   wire [7:0]  alu_b;
   wire [7:0]  alu_a;
   wire [7:0]  sum;
   wire        alu_c;
   wire        alu_dgc;
   wire        alu_z;

   // Phase counter runs free; a phase wrap marks one instruction cycle.
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   //-------------------------------------------------------------------
   // Opcode decode
   //-------------------------------------------------------------------
   // Decode from the latched word, so INSTR may change after Q1.
   assign is_alw = (ir_q[`CIS_OP_ALW_HI:`CIS_OP_ALW_LO]
                    == `CIS_OP_ALW_VAL);
   assign is_awf = (ir_q[`CIS_OP_FLD_HI:`CIS_OP_FLD_LO]
                    == `CIS_OP_AWF_VAL);
   assign is_inc = (ir_q[`CIS_OP_FLD_HI:`CIS_OP_FLD_LO]
                    == `CIS_OP_INC_VAL);
   assign is_br  = (ir_q[`CIS_OP_BR_HI:`CIS_OP_BR_LO]
                    == `CIS_OP_BR_VAL);
   assign dest   = ir_q[`CIS_DEST_BIT];
   assign faddr  = ir_q[`CIS_FADDR_HI:0];

   //-------------------------------------------------------------------
   // Arithmetic
   //-------------------------------------------------------------------
   // Increment reuses the adder with a constant one on the second input.
   assign alu_a = is_alw ? ir_q[`CIS_LIT_HI:0] : opnd_q;
   assign alu_b = is_inc ? 8'h01 : w_q;

   cis_alu u_alu (
      .a                (alu_a),
      .b                (alu_b),
      .sum              (sum),
      .carry            (alu_c),
      .digit_carry_flag (alu_dgc),
      .zero             (alu_z)
   );

   //-------------------------------------------------------------------
   // Execution pipeline across Q1..Q4
   //-------------------------------------------------------------------
   // Q1 latches the word, Q2 reads the operand, Q3 computes, Q4 writes.
   // Results are staged so that destination, flags and program counter
   // all change on one edge; no result becomes visible before Q4.
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ir_q      <= 14'h0000;
         opnd_q    <= 8'h00;
         res_q     <= 8'h00;
         c_res_q   <= 1'b0;
         dgc_res_q <= 1'b0;
         z_res_q   <= 1'b0;
         nop_q     <= 1'b1;
         pc_q      <= `CIS_PC_RST;
         w_q       <= `CIS_W_RST;
         c_q       <= 1'b0;
         dgc_q     <= 1'b0;
         z_q       <= 1'b0;
      end else begin
         case (phase_q)
            PH_DECODE: begin
               // Decode; the slot after a branch stays idle.
               if (!nop_q) begin
                  ir_q <= INSTR;
               end else begin
                  ir_q <= 14'h0000;
               end
            end
            PH_READ: begin
               // An idle slot leaves the operand latch alone.
               if (!nop_q) begin
                  opnd_q <= file_rd[faddr];
               end
            end
            PH_PROCESS: begin
               if (!nop_q) begin
                  res_q     <= sum;
                  c_res_q   <= alu_c;
                  dgc_res_q <= alu_dgc;
                  z_res_q   <= alu_z;
               end
            end
            PH_WRITE: begin
               nop_q <= 1'b0;
               if (nop_q) begin
                  pc_q <= pc_q;
               end else if (is_br) begin
                  // Flags untouched; the fetched next word is flushed.
                  pc_q  <= {PC_LATCH_HIGH[`CIS_PCLH_HI:`CIS_PCLH_LO],
                            ir_q[`CIS_BR_LIT_HI:0]};
                  nop_q <= 1'b1;
               end else begin
                  // Unknown words fall through here and only advance PC.
                  pc_q <= pc_q + 13'h0001;
                  if (is_alw || is_awf) begin
                     c_q   <= c_res_q;
                     dgc_q <= dgc_res_q;
                     z_q   <= z_res_q;
                  end else if (is_inc) begin
                     // Increment leaves carry and digit carry as they were.
                     z_q <= z_res_q;
                  end
                  if (is_alw || ((is_awf || is_inc) && !dest)) begin
                     w_q <= res_q;
                  end
               end
            end
            default: begin
               nop_q <= nop_q;
            end
         endcase
      end
   end

   //-------------------------------------------------------------------
   // File registers
   //-------------------------------------------------------------------
   // Write strobe for a file destination, only in Q4 of a live slot.
   assign file_we = (phase_q == PH_WRITE) && !nop_q
                    && (is_awf || is_inc) && dest;

   // One flip-flop entry per address. Entries clear at reset: that costs
   // a reset load per entry, but every write-back then starts from a
   // known value instead of an unknown one.
   generate
      for (gi = 0; gi < FILE_DEPTH; gi = gi + 1) begin : g_file
         reg [7:0] ent_q;
         always @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               ent_q <= `CIS_FILE_RST;
            end else if (file_we && ({25'h0, faddr} == gi)) begin
               ent_q <= res_q;
            end
         end
         assign file_rd[gi] = ent_q;
      end
   endgenerate

   //-------------------------------------------------------------------
   // Outputs
   //-------------------------------------------------------------------
   assign PC               = pc_q;
   assign PHASE            = phase_q;
   assign INSTR_FETCH      = (phase_q == PH_DECODE);
   assign WORK             = w_q;
   assign CARRY            = c_q;
   assign DIGIT_CARRY_FLAG = dgc_q;
   assign ZERO             = z_q;
   assign BRANCH_BUSY      = nop_q;
   assign FILE_ADDR        = faddr;
   assign FILE_DATA        = opnd_q;
   // Cleared select picks the external ladder, set picks the pump.
   assign BIAS_PUMP_EN     = LCD_BIAS_SOURCE_SELECT;
   assign BIAS_LADDER_EN   = !LCD_BIAS_SOURCE_SELECT;
endmodule // cis_core

// *** testbench/cis_core_props.sv ***
// Assertion checker for the core subset decoder, bound to cis_core.
`timescale 1ns/1ps
module cis_chk (
   input wire        CLK,
   input wire        RST_N,
   input wire [13:0] INSTR,
   input wire [7:0]  PC_LATCH_HIGH,
   input wire        LCD_BIAS_SOURCE_SELECT,
   input wire [12:0] PC,
   input wire [1:0]  PHASE,
   input wire        INSTR_FETCH,
   input wire [7:0]  WORK,
   input wire        CARRY,
   input wire        DIGIT_CARRY_FLAG,
   input wire        ZERO,
   input wire        BRANCH_BUSY,
   input wire        BIAS_PUMP_EN,
   input wire        BIAS_LADDER_EN
);
   // One clock domain, so clock and reset are given once.
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // A word is taken only in phase 0 of a slot that is not idle.
   wire go = PHASE == 2'h0 && !BRANCH_BUSY;
   a_phase_step: assert property (RST_N |=>
      PHASE == $past(PHASE) + 2'h1) else $error("phase order");
   a_fetch_flag: assert property (INSTR_FETCH == (PHASE == 2'h0))
      else $error("fetch flag");
   a_bias_pick: assert property (BIAS_PUMP_EN == LCD_BIAS_SOURCE_SELECT
      && BIAS_LADDER_EN != LCD_BIAS_SOURCE_SELECT) else $error("bias");
   a_hold_state: assert property (PHASE != 2'h3 |=> $stable(WORK)
      && $stable(PC)) else $error("early write");
   a_lit_sum: assert property (go && INSTR[13:9] == 5'h1F |-> ##4
      WORK == $past(WORK, 4) + $past(INSTR[7:0], 4)
      && ZERO == (WORK == 8'h00)) else $error("literal sum");
   a_br_target: assert property (go && INSTR[13:11] == 3'h5 |-> ##4
      PC == {$past(PC_LATCH_HIGH[4:3]), $past(INSTR[10:0], 4)}
      && BRANCH_BUSY) else $error("branch target");
   a_br_flags: assert property (go && INSTR[13:11] == 3'h5 |-> ##4
      CARRY == $past(CARRY, 4) && ZERO == $past(ZERO, 4)
      && DIGIT_CARRY_FLAG == $past(DIGIT_CARRY_FLAG, 4))
      else $error("branch flags");
   a_idle_slot: assert property (RST_N && BRANCH_BUSY
      && PHASE == 2'h0 |-> ##4 PC == $past(PC, 4)
      && WORK == $past(WORK, 4) && !BRANCH_BUSY)
      else $error("idle slot");
   a_inc_carry: assert property (go && INSTR[13:8] == 6'h0A |-> ##4
      CARRY == $past(CARRY, 4)
      && DIGIT_CARRY_FLAG == $past(DIGIT_CARRY_FLAG, 4))
      else $error("increment carry");
   a_file_dest: assert property (go && (INSTR[13:7] == 7'h0F
      || INSTR[13:7] == 7'h15) |-> ##4 WORK == $past(WORK, 4))
      else $error("file destination");
   c_lit: cover property (go && INSTR[13:9] == 5'h1F);
   c_br: cover property (go && INSTR[13:11] == 3'h5);
   c_inc: cover property (go && INSTR[13:8] == 6'h0A);
endmodule // cis_chk
bind cis_core cis_chk chk_u (.*);

// *** testbench/test_core_instruction_subset_exec.sv ***
// Self-checking bench for the core subset decoder and executor.
`timescale 1ns/1ps
module test_core_instruction_subset_exec;
   reg         CLK = 1'b0;
   reg         RST_N = 1'b0;
   reg  [13:0] INSTR = 14'h0000;
   reg  [7:0]  pclh = 8'h00;
   reg         sel = 1'b1;
   wire [12:0] pc;
   wire [7:0]  w;
   wire [6:0]  fa;
   wire [1:0]  ph;
   wire [7:0]  fd;
   wire        c, dgc, z, busy, pump, ladder;
   integer     mismatches = 0;
   integer     checks = 0;
   cis_core dut_u (.CLK(CLK), .RST_N(RST_N), .INSTR(INSTR),
      .PC_LATCH_HIGH(pclh), .LCD_BIAS_SOURCE_SELECT(sel), .PC(pc),
      .PHASE(ph), .INSTR_FETCH(), .WORK(w), .CARRY(c),
      .DIGIT_CARRY_FLAG(dgc), .ZERO(z), .BRANCH_BUSY(busy),
      .BIAS_PUMP_EN(pump), .BIAS_LADDER_EN(ladder), .FILE_ADDR(fa),
      .FILE_DATA(fd));
   // Counts every comparison and reports each one that differs.
   task ck(input string n, input [12:0] s, input [12:0] e);
      checks = checks + 1;
      if (s !== e) begin
         mismatches = mismatches + 1;
         $display("unexpected %0s expected %h seen %h", n, e, s);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Places a word for the next slot, then a no-op so it runs once.
   task run(input [13:0] i);
      integer n;
      n = 0;
      while (!(ph === 2'h3 && busy === 1'b0) && n < 40) begin
         @(negedge CLK);
         n = n + 1;
      end
      if (n == 40) begin
         mismatches = mismatches + 1;
         tally_and_finish;
      end
      @(posedge CLK) INSTR <= i;
      @(posedge CLK) INSTR <= 14'h0000;
      repeat (3) @(posedge CLK);
      @(negedge CLK);
   endtask
   // Two literal adds: a plain sum, then a wrap that sets every flag.
   task t_literal;
      run(14'h3F15);
      ck("work", w, 8'h15);
      ck("flags", {c, dgc, z}, 3'h0);
      run(14'h3EEB);
      ck("work", w, 8'h00);
      ck("flags", {c, dgc, z}, 3'h7);
   endtask
   task t_branch;
      @(posedge CLK) pclh <= 8'h18;
      run(14'h2FFF);
      ck("pc", pc, 13'h1FFF);
      ck("busy", busy, 1'b1);
      ck("flags", {c, dgc, z}, 3'h7);
      repeat (4) @(posedge CLK);
      @(negedge CLK);
      ck("pc", pc, 13'h1FFF);
      @(posedge CLK) pclh <= 8'h08;
      run(14'h2923);
      ck("pc", pc, 13'h0923);
   endtask
   // File registers clear at reset; one entry is walked through known sums.
   task t_file;
      run(14'h0AD5);
      ck("work", w, 8'h00);
      ck("flags", {c, dgc, z}, 3'h6);
      run(14'h0755);
      ck("work", w, 8'h01);
      ck("fdata", fd, 8'h01);
      ck("addr", fa, 7'h55);
      ck("flags", {c, dgc, z}, 3'h0);
      run(14'h3EFE);
      run(14'h07D5);
      ck("work", w, 8'hFF);
      ck("flags", {c, dgc, z}, 3'h7);
      run(14'h0A55);
      ck("work", w, 8'h01);
      ck("fdata", fd, 8'h00);
      ck("flags", {c, dgc, z}, 3'h6);
   endtask
   task t_bias;
      integer v;
      for (v = 0; v < 2; v = v + 1) begin
         @(posedge CLK) sel <= v[0];
         @(negedge CLK);
         ck("bias", {pump, ladder}, {v[0], !v[0]});
      end
   endtask
   // Core clock at 250 MHz.
   initial forever #2 CLK = ~CLK;
   // Branch runs before file work, whose flag checks start from its flags.
   initial begin
      repeat (12) @(posedge CLK);
      RST_N <= 1'b1;
      t_literal;
      t_branch;
      t_file;
      t_bias;
      tally_and_finish;
   end
endmodule // test_core_instruction_subset_exec
